/* File: logic/fjl_pkg.sv */
package fjl_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_SEC      = 1;
  localparam int unsigned TICK_CYCLES   = TICK_SEC * CLK_HZ;
  localparam int unsigned SLOT_HOURS    = 36;
  localparam int unsigned SLOT_TICKS    = SLOT_HOURS * 3600 / TICK_SEC;
  localparam int unsigned NUM_SLOTS     = 20;
  localparam int unsigned NUM_LEVELS    = 3;

  // Smoke in 0.1 %/m, temperature in deg, rise in deg per 168 s
  localparam logic [7:0]  SMK_THR_SIMPLE = 8'h28;   // 4.0 %/m
  localparam logic [7:0]  SMK_THR_NORMAL = 8'h32;   // 5.0 %/m
  localparam logic [7:0]  SMK_THR_CLEAN  = 8'h25;   // 3.7 %/m
  localparam logic [7:0]  TMP_THR        = 8'h39;   // 57 deg
  localparam logic [7:0]  RISE_THR       = 8'h12;   // 18 deg
  localparam logic [7:0]  RISE_SCALE     = 8'h0A;   // Rise scaled to 0.1 units
  // Combined score in 0.1 units
  localparam logic [11:0] CMB_THR_NORMAL = 12'h078; // 12
  localparam logic [11:0] CMB_THR_CLEAN  = 12'h064; // 10
  localparam logic [11:0] CMB_THR_COOK   = 12'h08C; // 14
  localparam logic [7:0]  CMB_MIN_SMK    = 8'h19;   // 2.5 %/m
  localparam logic [7:0]  CMB_MIN_RISE   = 8'h03;   // 3 deg
  localparam logic [7:0]  LVL2_RISE      = 8'h0C;   // 12 deg
  localparam logic [11:0] LVL3_CMB       = 12'h064; // 10

  // Pulse counter
  localparam logic [4:0]  CNT_RST        = 5'h00;
  localparam logic [4:0]  CNT_FIRE       = 5'h09;
  localparam logic [4:0]  CNT_MAX        = 5'h1F;
  localparam logic [6:0]  STEP_SMK_UP    = 7'h01;
  localparam logic [6:0]  STEP_TMP_UP    = 7'h03;
  localparam logic [6:0]  STEP_CMB_UP    = 7'h01;
  localparam logic [6:0]  STEP_DOWN      = 7'h02;
  localparam int unsigned SLOT_MARK_MIN  = 3;

  // Register map (word index on the plain port)
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h1;
  localparam logic [3:0]  REG_LEARN      = 4'h2;
  localparam logic [3:0]  REG_MARKS0     = 4'h3;
  localparam int unsigned CTRL_MULTI_BIT = 0;
  localparam int unsigned CTRL_DLY_LSB   = 1;
  localparam int unsigned CTRL_CLR_BIT   = 7;
  localparam logic        MULTI_RST      = 1'b1;
  localparam logic [5:0]  DELAY_RST      = 6'h09;
  localparam logic [5:0]  DELAY_MAX      = 6'h3C;   // 60 s ceiling

  typedef enum logic [4:0] {
    COND_NORMAL  = 5'b00001,
    COND_STEAM   = 5'b00010,
    COND_HEATING = 5'b00100,
    COND_COOKING = 5'b01000,
    COND_CLEAN   = 5'b10000
  } fjl_cond_e;

  typedef enum logic [2:0] {
    JDG_IDLE  = 3'b001,
    JDG_DELAY = 3'b010,
    JDG_ALARM = 3'b100
  } fjl_jdg_e;

  typedef struct packed {
    logic [7:0] smoke;
    logic [7:0] temp;
    logic [7:0] rise;
  } fjl_sense_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fjl_bus_s;

endpackage

/* File: logic/fjl_mark_ring.sv */
`timescale 1ns/1ps
module fjl_mark_ring (
  input  wire logic        clk,      // Core clock
  input  wire logic        rst_n,    // Synchronised reset, active low
  input  wire logic        event_in, // Level event this cycle
  input  wire logic [4:0]  cur_idx,  // Current slot
  input  wire logic        clr,      // Slot boundary pulse
  input  wire logic [4:0]  nxt_idx,  // Slot about to start
  output logic      [19:0] marks,    // One mark per slot
  output logic             three_up, // Three or more marks
  output logic             any_mark  // At least one mark
);
  import fjl_pkg::*;

  logic [4:0] pop;

  // One flag per slot; a hit in the boundary cycle beats the clear
  genvar i;
  generate
    for (i = 0; i < NUM_SLOTS; i++) begin : g_slot
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          marks[i] <= 1'b0;
        end else if (event_in && cur_idx == 5'(i)) begin
          marks[i] <= 1'b1;
        end else if (clr && nxt_idx == 5'(i)) begin
          marks[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mark count over the whole learning period
  always_comb begin
    pop = 5'h00;
    for (int k = 0; k < NUM_SLOTS; k++) begin
      pop = pop + {4'h0, marks[k]};
    end
  end

  assign three_up = (pop >= 5'(SLOT_MARK_MIN));
  assign any_mark = |marks;

endmodule // fjl_mark_ring

/* File: logic/fjl_top.sv */
`timescale 1ns/1ps
module fjl_top #(
  parameter int unsigned TICK_LEN = fjl_pkg::TICK_CYCLES, // Clocks per second tick
  parameter int unsigned SLOT_LEN = fjl_pkg::SLOT_TICKS   // Ticks per 36 h slot
) (
  input  wire logic                CORE_CLK,   // 20 MHz core clock
  input  wire logic                RSTN,       // Asynchronous reset, active low
  input  wire fjl_pkg::fjl_sense_s SENSE,      // Front end samples
  input  wire fjl_pkg::fjl_bus_s   BUS,        // Register port request
  output logic              [31:0] RD_DATA,    // Read data, cycle after read
  output logic              [4:0]  PULSE_CNT,  // Pulse counter
  output logic                     FIRE_JUDGE, // Counter at nine or above
  output logic                     FIRE_ALARM, // Fire alarm output
  output logic              [4:0]  LEARN_COND, // One-hot learning condition
  output logic              [2:0]  LEVEL_EVT   // Level three..one events
);
  import fjl_pkg::*;

  // Reset release and input synchronisers
  logic       rst_meta;
  logic       rst_n;
  fjl_sense_s sense_meta;
  fjl_sense_s sense;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Multi-bit samples are assumed to sit still between updates
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sense_meta <= '0;
      sense      <= '0;
    end else begin
      sense_meta <= SENSE;
      sense      <= sense_meta;
    end
  end

  // One-second tick from the core clock
  logic [31:0] tick_cnt;
  logic        tick;
  wire         tick_wrap = (tick_cnt == 32'(TICK_LEN - 1));

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 32'h0000_0001;
      tick     <= tick_wrap;
    end
  end

  // Control register state
  logic       multi;
  logic [5:0] delay_sec;
  logic       alarm_clr;
  fjl_cond_e  cond;

  // Thresholds applied under the present condition
  wire [7:0]  smk_thr = !multi ? SMK_THR_SIMPLE :
                        (cond == COND_CLEAN) ? SMK_THR_CLEAN : SMK_THR_NORMAL;
  wire [11:0] cmb_thr = (cond == COND_CLEAN)   ? CMB_THR_CLEAN :
                        (cond == COND_COOKING) ? CMB_THR_COOK  : CMB_THR_NORMAL;
  wire        rise_on = (cond != COND_HEATING);

  // Combined score twice smoke plus rise, both in 0.1 units
  wire [11:0] rise_x10 = 12'(sense.rise) * 12'(RISE_SCALE);
  wire [11:0] combined_score = {3'h0, sense.smoke, 1'b0} + rise_x10;
  wire        cmb_valid = (sense.smoke >= CMB_MIN_SMK) &&
                          (sense.rise >= CMB_MIN_RISE);

  // Per-cause comparisons
  wire smk_hit  = (sense.smoke >= smk_thr);
  wire tmp_hit  = (sense.temp >= TMP_THR) ||
                  (rise_on && sense.rise >= RISE_THR);
  wire cmb_hit  = cmb_valid && (combined_score >= cmb_thr);

  // Level events feeding the learning engine
  wire lvl1 = (sense.smoke >= {1'b0, smk_thr[7:1]});
  wire lvl2 = (sense.rise >= LVL2_RISE);
  wire lvl3 = cmb_valid && (combined_score >= LVL3_CMB);

  // Step per cause; simple variant counts smoke only
  wire [6:0] d_smk = smk_hit ? STEP_SMK_UP : -STEP_DOWN;
  wire [6:0] d_tmp = !multi ? 7'h00 :
                     tmp_hit ? STEP_TMP_UP : -STEP_DOWN;
  wire [6:0] d_cmb = !multi ? 7'h00 :
                     cmb_hit ? STEP_CMB_UP : -STEP_DOWN;

  // All causes summed in fixed order smoke, temperature, combined
  wire [6:0] cnt_sum = {2'b00, PULSE_CNT} + d_smk + d_tmp + d_cmb;
  wire [4:0] next_cnt = cnt_sum[6] ? CNT_RST :
                        (cnt_sum > {2'b00, CNT_MAX}) ? CNT_MAX : cnt_sum[4:0];

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PULSE_CNT <= CNT_RST;
    end else if (tick) begin
      PULSE_CNT <= next_cnt;
    end
  end

  // Fire judgement and alarm sequencing
  fjl_jdg_e   jdg;
  fjl_jdg_e   next_jdg;
  logic [5:0] dly_cnt;
  wire        judge_now = (PULSE_CNT >= CNT_FIRE);
  wire [5:0]  dly_load = (delay_sec > DELAY_MAX) ? DELAY_MAX : delay_sec;

  always_comb begin
    next_jdg = jdg;
    case (jdg)
      JDG_IDLE: begin
        if (judge_now) begin
          next_jdg = (!multi || dly_load == 6'h00) ? JDG_ALARM : JDG_DELAY;
        end
      end
      JDG_DELAY: begin
        if (!judge_now) begin
          next_jdg = JDG_IDLE;
        end else if (tick && dly_cnt <= 6'h01) begin
          next_jdg = JDG_ALARM;
        end
      end
      JDG_ALARM: begin
        if (alarm_clr && !judge_now) begin
          next_jdg = JDG_IDLE;
        end
      end
      default: next_jdg = JDG_IDLE;
    endcase
  end

  // Delay counts whole seconds; alarm latches until software clears it while the counter is below nine
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      jdg        <= JDG_IDLE;
      dly_cnt    <= 6'h00;
      FIRE_JUDGE <= 1'b0;
      FIRE_ALARM <= 1'b0;
    end else begin
      jdg        <= next_jdg;
      dly_cnt    <= (jdg == JDG_IDLE) ? dly_load :
                    (tick && dly_cnt != 6'h00) ? dly_cnt - 6'h01 : dly_cnt;
      FIRE_JUDGE <= judge_now;
      FIRE_ALARM <= (next_jdg == JDG_ALARM);
    end
  end

  // Slot timing: seconds within slot, slot index, first full period
  logic [31:0] sec_cnt;
  logic [4:0]  slot_idx;
  logic        period_done;
  wire         slot_end = tick && (sec_cnt == 32'(SLOT_LEN - 1));
  wire         last_slot = (slot_idx == 5'(NUM_SLOTS - 1));
  wire [4:0]   next_slot = last_slot ? 5'h00 : slot_idx + 5'h01;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt     <= '0;
      slot_idx    <= 5'h00;
      period_done <= 1'b0;
    end else if (tick) begin
      sec_cnt <= slot_end ? '0 : sec_cnt + 32'h0000_0001;
      if (slot_end) begin
        slot_idx <= next_slot;
        if (last_slot) begin
          period_done <= 1'b1;
        end
      end
    end
  end

  // One mark ring per level, only while learning is in use
  logic [2:0]  lvl_vec;
  logic [2:0]  three_up;
  logic [2:0]  any_mark;
  logic [19:0] marks [NUM_LEVELS];

  assign lvl_vec = {lvl3, lvl2, lvl1} & {3{multi}};

  genvar g;
  generate
    for (g = 0; g < NUM_LEVELS; g++) begin : g_lvl
      fjl_mark_ring u_ring (
        .clk      (CORE_CLK),
        .rst_n    (rst_n),
        .event_in (lvl_vec[g]),
        .cur_idx  (slot_idx),
        .clr      (slot_end),
        .nxt_idx  (next_slot),
        .marks    (marks[g]),
        .three_up (three_up[g]),
        .any_mark (any_mark[g])
      );
    end
  endgenerate

  // Condition choice; level conditions outrank clean, cooking first
  fjl_cond_e next_cond;
  assign next_cond = !multi      ? COND_NORMAL  :
                     three_up[2] ? COND_COOKING :
                     three_up[1] ? COND_HEATING :
                     three_up[0] ? COND_STEAM   :
                     (period_done && !(|any_mark)) ? COND_CLEAN :
                     COND_NORMAL;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cond       <= COND_NORMAL;
      LEARN_COND <= COND_NORMAL;
      LEVEL_EVT  <= 3'b000;
    end else begin
      cond       <= next_cond;
      LEARN_COND <= next_cond;
      LEVEL_EVT  <= lvl_vec;
    end
  end

  // Register port decode
  wire wr_ctrl = BUS.wr && (BUS.addr == REG_CTRL);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      multi     <= MULTI_RST;
      delay_sec <= DELAY_RST;
      alarm_clr <= 1'b0;
    end else begin
      alarm_clr <= wr_ctrl && BUS.wdata[CTRL_CLR_BIT];
      if (wr_ctrl) begin
        multi     <= BUS.wdata[CTRL_MULTI_BIT];
        delay_sec <= BUS.wdata[CTRL_DLY_LSB +: 6];
      end
    end
  end

  // Read mux; unmapped words read as zero
  logic [31:0] rd_mux;
  always_comb begin
    case (BUS.addr)
      REG_CTRL:         rd_mux = {24'h0000_00, 1'b0, delay_sec, multi};
      REG_STATUS:       rd_mux = {20'h0_0000, LEVEL_EVT, FIRE_ALARM, FIRE_JUDGE, 2'b00,
                                  PULSE_CNT};
      REG_LEARN:        rd_mux = {17'h0_0000, period_done, 1'b0, slot_idx, 3'b000,
                                  cond};
      REG_MARKS0:       rd_mux = {12'h000, marks[0]};
      REG_MARKS0 + 4'h1: rd_mux = {12'h000, marks[1]};
      REG_MARKS0 + 4'h2: rd_mux = {12'h000, marks[2]};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RD_DATA <= 32'h0000_0000;
    end else begin
      RD_DATA <= BUS.rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // fjl_top

/* File: verification/fjl_monitor.sv */
`timescale 1ns/1ps
module fjl_monitor #(
  parameter int unsigned TICK_LEN = 8, // Clocks per tick, at least 8 here
  parameter int unsigned SLOT_LEN = 3  // Ticks per slot
) (
  input wire logic                CORE_CLK,   // Core clock
  input wire logic                RSTN,       // Reset, active low
  input wire fjl_pkg::fjl_sense_s SENSE,      // Front end samples
  input wire fjl_pkg::fjl_bus_s   BUS,        // Register port
  input wire logic         [31:0] RD_DATA,    // Read data
  input wire logic         [4:0]  PULSE_CNT,  // Pulse counter
  input wire logic                FIRE_JUDGE, // Judgement
  input wire logic                FIRE_ALARM, // Alarm
  input wire logic         [4:0]  LEARN_COND, // Learning condition
  input wire logic         [2:0]  LEVEL_EVT   // Level events
);
  import fjl_pkg::*;
  logic multi;
  // Mirror of the multi-sensor enable, since the level events are masked without it
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) multi <= MULTI_RST;
    else if (BUS.wr && BUS.addr == REG_CTRL) multi <= BUS.wdata[CTRL_MULTI_BIT];
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // Windows of seven cover the two-flop sense path and the event register
  chk_judge_level: assert property (FIRE_JUDGE == ($past(PULSE_CNT) >= CNT_FIRE))
    else $error("judge does not follow counter");
  chk_cnt_hold: assert property ($changed(PULSE_CNT) |=> $stable(PULSE_CNT)[*7])
    else $error("counter moved between ticks");
  chk_cnt_no_wrap: assert property ({1'b0, PULSE_CNT} <= {1'b0, $past(PULSE_CNT)} + 6'h05)
    else $error("counter rose too far or wrapped");
  chk_cnt_drop_max: assert property ($past(PULSE_CNT) > 5'h06 |->
    PULSE_CNT >= $past(PULSE_CNT) - 5'h06) else $error("counter fell too far");
  chk_alarm_cause: assert property ($rose(FIRE_ALARM) |->
    (PULSE_CNT >= CNT_FIRE || $past(PULSE_CNT) >= CNT_FIRE)) else $error("alarm without judgement");
  chk_cond_onehot: assert property ($onehot(LEARN_COND))
    else $error("condition not one-hot");
  chk_clean_drop: assert property (LEVEL_EVT != 3'h0 |-> ##[0:2] LEARN_COND != COND_CLEAN)
    else $error("clean kept after an event");
  chk_lvl2_rise: assert property ((multi && $stable(SENSE.rise))[*7] |->
    LEVEL_EVT[1] == (SENSE.rise >= LVL2_RISE)) else $error("level two event wrong");
  chk_lvl1_half: assert property (
    (multi && LEARN_COND == COND_NORMAL && $stable(SENSE.smoke))[*7]
    |-> LEVEL_EVT[0] == (SENSE.smoke >= 8'h19)) else $error("level one event wrong");
endmodule // fjl_monitor

bind fjl_top fjl_monitor #(.TICK_LEN(TICK_LEN), .SLOT_LEN(SLOT_LEN)) fjl_monitor_inst (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .SENSE(SENSE), .BUS(BUS), .RD_DATA(RD_DATA),
  .PULSE_CNT(PULSE_CNT), .FIRE_JUDGE(FIRE_JUDGE), .FIRE_ALARM(FIRE_ALARM),
  .LEARN_COND(LEARN_COND), .LEVEL_EVT(LEVEL_EVT));

/* File: verification/fjl_front_model.sv */
`timescale 1ns/1ps
module fjl_front_model (
  input  wire logic          clk,   // Core clock
  input  wire logic    [7:0] smoke, // Commanded smoke, 0.1 %/m
  input  wire logic    [7:0] temp,  // Commanded temperature
  input  wire logic    [7:0] rise,  // Commanded rise per 168 s
  output fjl_pkg::fjl_sense_s sense  // Samples to the block
);
  import fjl_pkg::*;
  // A converter output only moves after an edge, so it adds one cycle of lag
  always @(posedge clk) begin
    sense <= '{smoke: smoke, temp: temp, rise: rise};
  end
endmodule // fjl_front_model

/* File: verification/test_fire_judgement_learning.sv */
`timescale 1ns/1ps
module test_fire_judgement_learning;
  import fjl_pkg::*;
  localparam int TICK = 8; // Long enough for the sense lag to settle before a tick
  localparam int SLOT = 3;
  localparam int SCYC = TICK * SLOT;
  logic        clk;
  logic        rstn;
  fjl_bus_s    bus;
  logic [7:0]  smk, tmp, rse;
  fjl_sense_s  sense;
  logic [31:0] rd_data, d;
  logic [4:0]  cnt, cond, e;
  logic        judge, alarm;
  logic [2:0]  evt;
  int          errors, cmp_count, cyc_n;

  fjl_front_model fjl_front_model_inst (.clk(clk), .smoke(smk), .temp(tmp), .rise(rse),
    .sense(sense));
  fjl_top #(.TICK_LEN(TICK), .SLOT_LEN(SLOT)) fjl_top_inst (.CORE_CLK(clk), .RSTN(rstn),
    .SENSE(sense), .BUS(bus), .RD_DATA(rd_data), .PULSE_CNT(cnt), .FIRE_JUDGE(judge),
    .FIRE_ALARM(alarm), .LEARN_COND(cond), .LEVEL_EVT(evt));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hung wait must still reach the verdict
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    v = rd_data;
    @(posedge clk);
  endtask

  task automatic sense_to(input logic [7:0] s, input logic [7:0] t, input logic [7:0] r);
    smk <= s;
    tmp <= t;
    rse <= r;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Observe on the falling edge so the updates of the rising edge have landed
  task automatic next_cnt(input logic [4:0] x);
    logic [4:0] p;
    @(negedge clk);
    p = cnt;
    for (int i = 0; i < 20 && cnt === p; i++) @(negedge clk);
    cmp("pulse_cnt", {27'h0, x}, {27'h0, cnt});
    @(posedge clk);
  endtask

  task automatic t_reset();
    rd(REG_CTRL, d);
    cmp("ctrl", 32'h0000_0013, d);
    rd(4'hF, d);
    cmp("unmapped", 32'h0000_0000, d);
    rd(REG_LEARN, d);
    cmp("learn", 32'h0000_0001, d);
    cmp("cond", {27'h0, COND_NORMAL}, {27'h0, cond});
    cmp("pulse_cnt", 32'h0000_0000, {27'h0, cnt});
  endtask

  task automatic t_learn();
    cyc(20 * SCYC + 16);
    cmp("cond", {27'h0, COND_CLEAN}, {27'h0, cond});
    sense_to(8'h00, 8'h00, LVL2_RISE);
    cyc(6);
    cmp("evt", 32'h0000_0002, {29'h0, evt});
    cmp("cond", {27'h0, COND_NORMAL}, {27'h0, cond});
    cyc(3 * SCYC + TICK);
    cmp("cond", {27'h0, COND_HEATING}, {27'h0, cond});
    rd(REG_MARKS0 + 4'h1, d);
    cmp("marks_ge3", 32'h1, {31'h0, $countones(d) >= 3});
    sense_to(8'h00, 8'h00, 8'h00);
    cyc(21 * SCYC);
    cmp("cond", {27'h0, COND_CLEAN}, {27'h0, cond});
  endtask

  task automatic t_simple();
    wr(REG_CTRL, 32'h0000_0012);
    sense_to(SMK_THR_SIMPLE, 8'h00, 8'h00);
    for (int i = 1; i <= 9; i++) next_cnt(5'(i));
    sense_to(8'h00, 8'h00, 8'h00);
    cyc(2);
    cmp("judge", 32'h1, {31'h0, judge});
    cmp("alarm", 32'h1, {31'h0, alarm});
    cmp("evt", 32'h0, {29'h0, evt});
    rd(REG_STATUS, d);
    cmp("status", 32'h0000_0189, d);
    e = 5'h09;
    repeat (5) begin
      e = (e > 5'h02) ? e - 5'h02 : 5'h00;
      next_cnt(e);
    end
    cyc(3 * TICK);
    cmp("pulse_cnt", 32'h0, {27'h0, cnt});
    cmp("alarm", 32'h1, {31'h0, alarm});
    wr(REG_CTRL, 32'h0000_0092);
    cyc(2);
    cmp("alarm", 32'h0, {31'h0, alarm});
  endtask

  // Delay of zero alarms at once; a delay of 1 to 60 holds the alarm off for that many ticks, a larger one for 60.
  // The held sense steps +1 -2 +1, so the count rests at ten while the delay runs.
  task automatic t_multi(input logic [31:0] ctrl);
    wr(REG_CTRL, ctrl);
    sense_to(SMK_THR_NORMAL, TMP_THR, RISE_THR);
    next_cnt(5'h05);
    next_cnt(5'h0A);
    sense_to(SMK_THR_NORMAL, 8'h14, 8'h04);
    cyc(2);
    cmp("judge", 32'h1, {31'h0, judge});
    cmp("alarm", {31'h0, ctrl[6:1] == 6'h00}, {31'h0, alarm});
    for (int i = 0; i < 24 && alarm !== 1'b1; i++) @(posedge clk);
    cmp("alarm", 32'h1, {31'h0, alarm});
    cmp("pulse_cnt", 32'h0000_000A, {27'h0, cnt});
    sense_to(8'h1E, 8'h14, CMB_MIN_RISE);
    next_cnt(5'h04);
    next_cnt(5'h00);
    wr(REG_CTRL, ctrl | 32'h0000_0080);
    cyc(2);
    cmp("alarm", 32'h0, {31'h0, alarm});
  endtask

  task automatic t_rerst();
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(3);
    cmp("pulse_cnt", 32'h0, {27'h0, cnt});
    cmp("cond", {27'h0, COND_NORMAL}, {27'h0, cond});
  endtask

  initial begin
    rstn = 1'b0;
    bus = '0;
    smk = 8'h00;
    tmp = 8'h00;
    rse = 8'h00;
    errors = 0;
    cmp_count = 0;
    cyc_n = 0;
    cyc(3);
    rstn <= 1'b1;
    cyc(3);
    t_reset();
    t_learn();
    t_simple();
    t_multi(32'h0000_0001);
    t_multi(32'h0000_0005);
    t_rerst();
    give_verdict();
  end
endmodule // test_fire_judgement_learning
